// file: dts_pkg.sv
package dts_pkg;

    // ----------------------------------------------------------------
    // organisation of the array
    // ----------------------------------------------------------------
    localparam int DATA_W     = 36;
    localparam int ADDR_W     = 21;
    localparam int DEPTH      = 2097152;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int C_IDLE_NS      = 400;
    localparam int C_IDLE_CYC     = (C_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W     = 8;
    localparam logic [IDLE_CNT_W-1:0] C_IDLE_LIMIT = IDLE_CNT_W'(C_IDLE_CYC);

    // ----------------------------------------------------------------
    // link pin groups and reset values
    // ----------------------------------------------------------------
    localparam int CLK_PINS   = 4;
    localparam int PIN_K      = 0;
    localparam int PIN_K_N    = 1;
    localparam int PIN_C      = 2;
    localparam int PIN_C_N    = 3;
    localparam int CTL_W      = ADDR_W + DATA_W + 3;
    localparam logic [DATA_W-1:0]     DQ_RESET   = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0]     ADDR_RESET = 21'h00_0000;
    localparam logic [IDLE_CNT_W-1:0] CNT_RESET  = 8'h00;
    localparam logic [1:0]            STEP_RESET = 2'h0;
    localparam logic [1:0]            STEP_FIRST = 2'h1;

    // ----------------------------------------------------------------
    // read launch sequencer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        RD_IDLE   = 5'b00001,
        RD_WAIT   = 5'b00010,
        RD_HALF   = 5'b00100,
        RD_SECOND = 5'b01000,
        RD_TAIL   = 5'b10000
    } dts_rd_state_t;

endpackage : dts_pkg

// file: dts_sync.sv
`timescale 1ns/10ps
module dts_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise
);
    import dts_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;
    logic [2:0]   warm_reg;

    // two flops for the crossing, a third for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edges held back until all three flops carry the pin, so an idle-high pin gives no false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_reg <= '0;
        end else begin
            warm_reg <= {warm_reg[1:0], 1'b1};
        end
    end

    assign q    = sync_reg;
    assign rise = sync_reg & ~prev_reg & {W{warm_reg[2]}};

endmodule : dts_sync

// file: dts_array.sv
`timescale 1ns/10ps
module dts_array (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       wr_en,
    input  wire logic [dts_pkg::ADDR_W-1:0] wr_addr,
    input  wire logic [dts_pkg::DATA_W-1:0] wr_data,
    input  wire logic                       rd_en,
    input  wire logic [dts_pkg::ADDR_W-1:0] rd_addr,
    output logic      [dts_pkg::DATA_W-1:0] rd_data
);
    import dts_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] rd_data_reg;

    // self-timed write, no extra cycle asked of the controller
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data_reg <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;

    a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en |=> mem[$past(wr_addr)] == $past(wr_data))
        else $error("written word not in array");

endmodule : dts_array

// file: dts_port.sv
`timescale 1ns/10ps
// Functional notes
// - addresses taken only on alternate rising edges of the primary clock
// - write words taken on rising edges of primary clock and its complement
// - only rising edges of every received clock are used
// - read words launched on output clock pair, else on primary pair
// - one-bit burst counter from address lsb sequences two words
// - latency pin high: read data after one and a half cycles
// - latency pin low: read data after one cycle
// - shared data pins driven by device only for read words
// - echo strobes follow the launching clock, aligned with read data
// - array writes complete internally, no extra controller cycles
// - array is 2M words of 36 bits, widths follow
module dts_port (
    input  wire logic                       MCLK,
    input  wire logic                       ARST_N,
    input  wire logic                       K,
    input  wire logic                       K_N,
    input  wire logic                       C,
    input  wire logic                       C_N,
    input  wire logic [dts_pkg::ADDR_W-1:0] ADDR,
    input  wire logic                       LOAD_N,
    input  wire logic                       READ_NOT_WRITE,
    input  wire logic                       PLL_DISABLE_PIN,
    input  wire logic [dts_pkg::DATA_W-1:0] DQ_IN,
    output logic      [dts_pkg::DATA_W-1:0] DQ_OUT,
    output logic                            DQ_OE,
    output logic                            ECHO_STROBE,
    output logic                            ECHO_STROBE_N
);
    import dts_pkg::*;

    // ----------------------------------------------------------------
    // reset release and pin crossing
    // ----------------------------------------------------------------
    logic                rst_meta_reg;
    logic                rst_n_reg;
    logic [CLK_PINS-1:0] clk_lvl;
    logic [CLK_PINS-1:0] clk_rise;
    logic [CTL_W-1:0]    ctl_s;
    logic [ADDR_W-1:0]   addr_s;
    logic [DATA_W-1:0]   dq_s;
    logic                load_s;
    logic                rnw_s;
    logic                lat15_s;

    // reset leaves through two flops
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    dts_sync #(.W(CLK_PINS)) u_clk_sync (
        .clk   (MCLK),
        .rst_n (rst_n_reg),
        .d     ({C_N, C, K_N, K}),
        .q     (clk_lvl),
        .rise  (clk_rise)
    );

    dts_sync #(.W(CTL_W)) u_ctl_sync (
        .clk   (MCLK),
        .rst_n (rst_n_reg),
        .d     ({PLL_DISABLE_PIN, READ_NOT_WRITE, ~LOAD_N, DQ_IN, ADDR}),
        .q     (ctl_s),
        .rise  ()
    );

    // same depth on both paths keeps data aligned to its edge
    assign addr_s  = ctl_s[ADDR_W-1:0];
    assign dq_s    = ctl_s[ADDR_W+DATA_W-1:ADDR_W];
    assign load_s  = ctl_s[ADDR_W+DATA_W];
    assign rnw_s   = ctl_s[ADDR_W+DATA_W+1];
    assign lat15_s = ctl_s[ADDR_W+DATA_W+2];

    // ----------------------------------------------------------------
    // output clock selection
    // ----------------------------------------------------------------
    logic [IDLE_CNT_W-1:0] c_idle_reg;
    logic                  use_c_reg;
    logic                  k_rise;
    logic                  kn_rise;
    logic                  o_rise;
    logic                  o_fall;

    // falling edges are never looked at, only the complement's rise
    assign k_rise  = clk_rise[PIN_K];
    assign kn_rise = clk_rise[PIN_K_N];

    // output pair counts as supplied while its edges keep coming
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            c_idle_reg <= CNT_RESET;
            use_c_reg  <= 1'b0;
        end else begin
            if (clk_rise[PIN_C]) begin
                c_idle_reg <= CNT_RESET;
                use_c_reg  <= 1'b1;
            end else if (c_idle_reg < C_IDLE_LIMIT) begin
                c_idle_reg <= c_idle_reg + 1'b1;
            end else begin
                use_c_reg  <= 1'b0;
            end
        end
    end

    // launch edges: output pair if present, else primary pair
    assign o_rise = use_c_reg ? clk_rise[PIN_C]   : k_rise;
    assign o_fall = use_c_reg ? clk_rise[PIN_C_N] : kn_rise;

    // ----------------------------------------------------------------
    // address capture
    // ----------------------------------------------------------------
    logic              block_reg;
    logic              take;
    logic              rd_capture;
    logic              wr_capture;
    logic              rd_pend_reg;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic              rd_consume;

    // an edge right after an accepted address is skipped
    assign take       = k_rise && load_s && !block_reg;
    assign rd_capture = take && rnw_s;
    assign wr_capture = take && !rnw_s;

    // alternate-edge guard
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            block_reg <= 1'b0;
        end else if (k_rise) begin
            block_reg <= take;
        end
    end

    // one read may wait while the previous burst drains
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= ADDR_RESET;
        end else begin
            if (rd_capture) begin
                rd_pend_reg <= 1'b1;
                rd_addr_reg <= addr_s;
            end else if (rd_consume) begin
                rd_pend_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    logic              wr_armed_reg;
    logic              wr_second_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic              mem_wr_en;
    logic [ADDR_W-1:0] mem_wr_addr;

    // first word on the next primary rise, second on the complement rise
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_armed_reg  <= 1'b0;
            wr_second_reg <= 1'b0;
            wr_addr_reg   <= ADDR_RESET;
        end else begin
            if (wr_capture) begin
                wr_armed_reg <= 1'b1;
                wr_addr_reg  <= addr_s;
            end else if (k_rise && wr_armed_reg) begin
                wr_armed_reg  <= 1'b0;
                wr_second_reg <= 1'b1;
            end
            if (kn_rise && wr_second_reg) begin
                wr_second_reg <= 1'b0;
            end
        end
    end

    // burst counter flips the lsb for the second word
    assign mem_wr_en   = (k_rise && wr_armed_reg) || (kn_rise && wr_second_reg);
    assign mem_wr_addr = {wr_addr_reg[ADDR_W-1:1], wr_addr_reg[0] ^ wr_second_reg};

    // ----------------------------------------------------------------
    // read fetch and launch
    // ----------------------------------------------------------------
    dts_rd_state_t     state_reg;
    dts_rd_state_t     state_next;
    logic [1:0]        fetch_reg;
    logic              burst_bit_reg;
    logic [ADDR_W-1:0] fetch_base_reg;
    logic [ADDR_W-1:0] mem_rd_addr;
    logic [DATA_W-1:0] mem_rd_data;
    logic [DATA_W-1:0] word0_reg;
    logic [DATA_W-1:0] word1_reg;
    logic              launch0;
    logic              launch1;
    logic              release_bus;
    logic              second_edge;
    logic              tail_edge;
    logic [DATA_W-1:0] dq_out_reg;
    logic              dq_oe_reg;
    logic              echo_reg;
    logic              echo_n_reg;

    dts_array u_array (
        .clk     (MCLK),
        .rst_n   (rst_n_reg),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (dq_s),
        .rd_en   (rd_consume || fetch_reg[0]),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // edge order differs by latency mode
    assign second_edge = lat15_s ? o_rise : o_fall;
    assign tail_edge   = lat15_s ? o_fall : o_rise;
    assign rd_consume  = ((state_reg == RD_IDLE) || (state_reg == RD_TAIL && tail_edge)) && rd_pend_reg;
    assign launch0     = (state_reg == RD_WAIT && o_rise && !lat15_s && fetch_reg == STEP_RESET) ||
                         (state_reg == RD_HALF && o_fall);
    assign launch1     = state_reg == RD_SECOND && second_edge;
    assign release_bus = state_reg == RD_TAIL && tail_edge;

    // launch sequencer, a rise seen while words are still fetched belongs to the read's own cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RD_IDLE:   if (rd_pend_reg) state_next = RD_WAIT;
            RD_WAIT:   if (o_rise && fetch_reg == STEP_RESET) state_next = lat15_s ? RD_HALF : RD_SECOND;
            RD_HALF:   if (o_fall) state_next = RD_SECOND;
            RD_SECOND: if (second_edge) state_next = RD_TAIL;
            RD_TAIL:   if (tail_edge) state_next = rd_pend_reg ? RD_WAIT : RD_IDLE;
            default:   state_next = RD_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= RD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // two array reads per burst: taken address first, then lsb flipped
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fetch_reg      <= STEP_RESET;
            burst_bit_reg  <= 1'b0;
            fetch_base_reg <= ADDR_RESET;
        end else begin
            fetch_reg <= {fetch_reg[0], rd_consume};
            if (rd_consume) begin
                fetch_base_reg <= rd_addr_reg;
                burst_bit_reg  <= ~rd_addr_reg[0];
            end
        end
    end

    assign mem_rd_addr = rd_consume ? rd_addr_reg : {fetch_base_reg[ADDR_W-1:1], burst_bit_reg};

    // collect fetched words
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            word0_reg <= DQ_RESET;
            word1_reg <= DQ_RESET;
        end else begin
            if (fetch_reg == STEP_FIRST) begin
                word0_reg <= mem_rd_data;
            end
            if (fetch_reg[1]) begin
                word1_reg <= mem_rd_data;
            end
        end
    end

    // pins driven only while read words are out
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dq_out_reg <= DQ_RESET;
            dq_oe_reg  <= 1'b0;
        end else begin
            if (launch0) begin
                dq_out_reg <= word0_reg;
                dq_oe_reg  <= 1'b1;
            end else if (launch1) begin
                dq_out_reg <= word1_reg;
            end else if (release_bus) begin
                dq_oe_reg  <= 1'b0;
            end
        end
    end

    // echo strobes ride the same launch edges as the data
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            echo_reg   <= 1'b0;
            echo_n_reg <= 1'b1;
        end else if (o_rise) begin
            echo_reg   <= 1'b1;
            echo_n_reg <= 1'b0;
        end else if (o_fall) begin
            echo_reg   <= 1'b0;
            echo_n_reg <= 1'b1;
        end
    end

    assign DQ_OUT        = dq_out_reg;
    assign DQ_OE         = dq_oe_reg;
    assign ECHO_STROBE   = echo_reg;
    assign ECHO_STROBE_N = echo_n_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [1:0] k_since_take_reg;

    // primary rises seen since the last accepted address, saturating
    always_ff @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            k_since_take_reg <= STEP_FIRST;
        end else if (take) begin
            k_since_take_reg <= STEP_RESET;
        end else if (k_rise && !k_since_take_reg[1]) begin
            k_since_take_reg <= k_since_take_reg + STEP_FIRST;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n_reg);

    sequence s_write_armed;
        k_rise && wr_armed_reg;
    endsequence

    sequence s_first_out;
        launch0 ##1 dq_oe_reg;
    endsequence

    a_addr_alternate: assert property (take |-> k_since_take_reg != STEP_RESET)
        else $error("address taken on adjacent rising edge");
    a_word_pair: assert property (s_write_armed |=> wr_second_reg && !wr_armed_reg)
        else $error("second write word not armed");
    a_rising_only: assert property ((take || mem_wr_en) |-> (k_rise || kn_rise))
        else $error("capture without a rising edge");
    a_launch_clock: assert property (launch0 && use_c_reg |-> clk_rise[PIN_C] || clk_rise[PIN_C_N])
        else $error("launch not on output clock pair");
    a_burst_flip: assert property (fetch_reg == STEP_FIRST |-> mem_rd_addr[0] != $past(mem_rd_addr[0]))
        else $error("burst lsb did not flip");
    a_lat_half: assert property (launch0 && lat15_s |-> o_fall && $past(state_reg) != RD_IDLE)
        else $error("first read word not on half edge");
    a_lat_one: assert property (launch0 && !lat15_s |-> o_rise)
        else $error("first read word not on rising launch edge");
    a_bus_drive: assert property (dq_oe_reg == (state_reg == RD_SECOND || state_reg == RD_TAIL))
        else $error("pins driven outside a read burst");
    a_first_word: assert property (s_first_out |-> dq_out_reg == word0_reg)
        else $error("first read word not the fetched word");
    a_echo_align: assert property ((launch0 || launch1) |=> echo_reg == $past(o_rise) && echo_n_reg == !echo_reg)
        else $error("echo strobe out of step with data");

endmodule : dts_port

// file: dts_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// host controller model on the link side of the port
// ------------------------------------------------------------
module dts_host_model (
    input  wire logic                       c_on,
    output logic                            k,
    output logic                            k_n,
    output logic                            c,
    output logic                            c_n,
    output logic      [dts_pkg::ADDR_W-1:0] addr,
    output logic                            load_n,
    output logic                            rnw,
    output logic      [dts_pkg::DATA_W-1:0] dq,
    output logic                            dq_oe
);
    import dts_pkg::*;
    logic       lclk;
    logic [1:0] q_reg;

    // quarter-period clock, phase unrelated to mclk
    initial begin
        lclk   = 1'b0;
        q_reg  = 2'h2;
        k      = 1'b0;
        k_n    = 1'b1;
        c      = 1'b0;
        c_n    = 1'b0;
        addr   = '0;
        load_n = 1'b1;
        rnw    = 1'b1;
        dq     = '0;
        dq_oe  = 1'b0;
        #3.7;
        forever #10 lclk = ~lclk;
    end

    // link clocks, an edge every 40 ns, output pair trails by 20 ns
    always @(posedge lclk) begin
        q_reg <= q_reg + 2'h1;
        k     <= q_reg[0] == q_reg[1];
        k_n   <= q_reg[0] != q_reg[1];
        c     <= c_on & ~q_reg[1];
        c_n   <= c_on & q_reg[1];
    end

    // idle link cycles, pins released with a changing pattern
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge lclk iff q_reg == 2'h2);
            dq_oe <= 1'b0;
            dq    <= ~dq;
        end
    endtask : idle

    // one request, two k cycles long, so requests come every second k rise
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1, input logic dup);
        @(posedge lclk iff q_reg == 2'h2);
        dq_oe  <= 1'b0;
        dq     <= ~dq;
        addr   <= a;
        rnw    <= rd;
        load_n <= 1'b0;
        repeat (2) @(posedge lclk);
        load_n <= 1'b1;
        addr   <= ~a;
        rnw    <= ~rd;
        repeat (2) @(posedge lclk);
        if (!rd) begin
            dq    <= w0;
            dq_oe <= 1'b1;
        end
        if (dup) begin
            load_n <= 1'b0; // spacing broken on purpose
            rnw    <= 1'b0;
        end
        repeat (2) @(posedge lclk);
        load_n <= 1'b1;
        if (!rd) begin
            dq <= w1;
        end
        @(posedge lclk);
    endtask : xfer
endmodule : dts_host_model

// file: dts_port_tb_top.sv
`timescale 1ns/10ps
module dts_port_tb_top;
    import dts_pkg::*;
    logic                mclk, arst_n, lat_hi, c_on;
    logic                k, k_n, c, c_n, load_n, rnw, host_oe, oe, echo, echo_n;
    logic [ADDR_W-1:0]   addr, a, b;
    logic [DATA_W-1:0]   host_dq, dq_out, dq_wire;
    logic [31:0]         seed;
    logic [DATA_W-1:0]   mem [logic [ADDR_W-1:0]];
    logic [2*DATA_W:0]   notes [$];
    realtime             t_true, t_comp;
    int                  fails, tests_run, cycles;

    // ------------------------------------------------------------
    // clock, wire and instances
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    assign dq_wire = oe ? dq_out : host_dq;

    dts_port u_dut (
        .MCLK            (mclk),
        .ARST_N          (arst_n),
        .K               (k),
        .K_N             (k_n),
        .C               (c),
        .C_N             (c_n),
        .ADDR            (addr),
        .LOAD_N          (load_n),
        .READ_NOT_WRITE  (rnw),
        .PLL_DISABLE_PIN (lat_hi),
        .DQ_IN           (dq_wire),
        .DQ_OUT          (dq_out),
        .DQ_OE           (oe),
        .ECHO_STROBE     (echo),
        .ECHO_STROBE_N   (echo_n)
    );

    dts_host_model u_host (
        .c_on   (c_on),
        .k      (k),
        .k_n    (k_n),
        .c      (c),
        .c_n    (c_n),
        .addr   (addr),
        .load_n (load_n),
        .rnw    (rnw),
        .dq     (host_dq),
        .dq_oe  (host_oe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [DATA_W-1:0] rnd36();
        logic [31:0] lo;
        logic [31:0] hi;
        lo = xs();
        hi = xs();
        return {hi[3:0], lo};
    endfunction : rnd36

    task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // write a random pair, the dup flag adds a too-early request
    task automatic wr(input logic [ADDR_W-1:0] wa, input logic dup);
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
        w0 = rnd36();
        w1 = rnd36();
        mem[wa] = w0;
        mem[wa ^ 21'h0_0001] = w1;
        u_host.xfer(1'b0, wa, w0, w1, dup);
    endtask : wr

    // read, noting both words and the expected launch edge
    task automatic rd(input logic [ADDR_W-1:0] ra);
        notes.push_back({mem[ra], mem[ra ^ 21'h0_0001], lat_hi});
        u_host.xfer(1'b1, ra, '0, '0, 1'b0);
    endtask : rd

    // last rise of the launching pair
    always @(posedge k) if (!c_on) t_true = $realtime;
    always @(posedge c) t_true = $realtime;
    always @(posedge k_n) if (!c_on) t_comp = $realtime;
    always @(posedge c_n) t_comp = $realtime;

    // ------------------------------------------------------------
    // read monitor and pin ownership
    // ------------------------------------------------------------
    initial begin
        logic [2*DATA_W:0] n;
        forever begin
            @(posedge oe);
            #1;
            check("read pending", DATA_W'(notes.size() != 0), DATA_W'(1));
            n = notes.pop_front();
            check("word0", dq_out, n[2*DATA_W:DATA_W+1]);
            check("launch edge", DATA_W'(t_comp > t_true), DATA_W'(n[0]));
            check("echo", DATA_W'(echo), DATA_W'(!n[0]));
            @(echo);
            #1;
            check("word1", dq_out, n[DATA_W:1]);
            check("echo pair", DATA_W'(echo_n), DATA_W'(!echo));
        end
    end

    // device must stay off the pins during writes; hang guard
    always @(negedge mclk) begin
        cycles++;
        if (host_oe === 1'b1) check("device drive", DATA_W'(oe), '0);
        if (cycles == 6000) begin
            fails++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence: each latency with and without output clocks
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0000_001b;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        arst_n = 1'b0;
        lat_hi = 1'b0;
        c_on = 1'b0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check("oe after reset", DATA_W'(oe), '0);
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            lat_hi <= m[0];
            c_on <= m[1];
            u_host.idle(8);
            a = ADDR_W'(xs());
            b = ADDR_W'(xs());
            wr(a, 1'b0);
            rd(a);
            rd(a ^ 21'h0_0001);
            u_host.idle(2);
            wr(~b, 1'b0);
            wr(b, 1'b1);
            rd(~b);
            rd(b);
            u_host.idle(4);
        end
        u_host.idle(4);
        check("reads left", DATA_W'(notes.size()), '0);
        finish_test();
    end
endmodule : dts_port_tb_top
